// File: hdl/tcc_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * test configuration block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ============================================================
// Register word indexes and their byte addresses, one word per register
`define TCC_IDX_TEST_CONFIG 12'h01E
`define TCC_IDX_BAL_ENABLE 12'h014
`define TCC_IDX_BAL_CONFIG 12'h013
`define TCC_ADDR_TEST_CONFIG (`TCC_IDX_TEST_CONFIG << 2)
`define TCC_ADDR_BAL_ENABLE (`TCC_IDX_BAL_ENABLE << 2)
`define TCC_ADDR_BAL_CONFIG (`TCC_IDX_BAL_CONFIG << 2)
`define TCC_ADDR_COMM_TIMEOUT 12'h100
`define TCC_ADDR_STATUS 12'h104

// ============================================================
// Test configuration fields
`define TCC_RSVD_HI_MSB 15
`define TCC_RSVD_HI_LSB 12
`define TCC_REG_TRIAL_MSB 11
`define TCC_REG_TRIAL_LSB 8
`define TCC_CNT_INHIBIT_BIT 7
`define TCC_VDIG_TRIP_BIT 6
`define TCC_SQUEEZE_BIT 4
`define TCC_CP_MON_BIT 2
`define TCC_MOD_MON_BIT 0
`define TCC_TEST_CONFIG_MASK 16'h0FD5

// Balancing configuration field
`define TCC_BAL_CONT_BIT 3
`define TCC_BAL_CONFIG_MASK 16'h00F8

// ============================================================
// Reset values
`define TCC_TEST_CONFIG_RST 16'h0000
`define TCC_BAL_ENABLE_RST 16'h0000
`define TCC_BAL_CONFIG_RST 16'h0000
`define TCC_COMM_TIMEOUT_RST 32'h0000_0000

// ============================================================
// Timing
`define TCC_LATE_TIMEOUT_MIN 70
`define TCC_CLK_HZ 25000000

`endif

// File: hdl/tcc_drive_select.sv
/*
 * Routes balancing enable bits to balancing or squeeze outputs.
 * Assumes the enable vector already reflects fault clearing.
 */
`timescale 1ns/1ns
module tcc_drive_select
    import tcc_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    input wire logic [CHANNELS-1:0] enable_bits,
    input wire logic squeeze_on,
    output logic [CHANNELS-1:0] balance_drive,
    output logic [CHANNELS-1:0] squeeze_drive
);
    // ============================================================
    // Per channel steering; bit 0 feeds cell 1
    generate
        for (genvar i = 0; i < CHANNELS; i++)
        begin : g_ch
            assign balance_drive[i] = enable_bits[i] & ~squeeze_on;
            assign squeeze_drive[i] = enable_bits[i] & squeeze_on;
        end
    endgenerate
endmodule

// File: hdl/tcc_pkg.sv
/*
 * Types of the test configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcc_pkg;
    // ============================================================
    // Test outputs carried together
    typedef struct packed {
        logic [3:0] core_regulator_trial_field;
        logic counter_reset_inhibit;
        logic digital_supply_trip_armed;
        logic squeeze_resistor_enable;
        logic charge_pump_monitor_enable;
        logic module_voltage_monitor_enable;
    } tcc_test_ctl_t;

    // Balancing drive outputs
    typedef struct packed {
        logic [15:0] balance_drive;
        logic [15:0] squeeze_drive;
    } tcc_bal_drive_t;

    typedef enum logic [1:0] {
        TCC_WR_IDLE,
        TCC_WR_RESP
    } tcc_wr_state_t;
endpackage

// File: hdl/tcc_test_config.sv
/*
 * Test configuration register block with AXI4-Lite slave, balancing
 * enable handling, comm timeout counter and shutdown arming.
 * Assumes one clock, inputs synchronous to sys_clk, active high reset.
 */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tcc_defs.svh"

// Behaviour
// - Top four bits read zero always
// - Inhibit bit stops counter reset on packets
// - Low period while inhibited misses timeout
// - Writing new timeout count restores behaviour
// - Trip test bit arms shutdown on trip
// - Arming persists until shutdown, bit reads back as written
// - Squeeze bit routes enables to resistors
// - Enable bit n drives cell n+1 output
// - Faults clear enables unless balance-continue set
// - Charge pump monitor enable follows bit 2
// - Module monitor enable follows bit 0
module tcc_test_config
    import tcc_pkg::*;
#(
    parameter int CHANNELS = 16,
    parameter int FAULT_BITS = 8
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic valid_packet,
    input wire logic [FAULT_BITS-1:0] fault_bits,
    input wire logic customer_checksum_error,
    input wire logic digital_supply_por_trip,
    input wire logic [31:0] comm_power_down_period,
    output tcc_test_ctl_t test_ctl,
    output tcc_bal_drive_t bal_drive,
    output logic shutdown_request,
    output logic comm_timeout
);
    // ============================================================
    // Parameter limits the register layout can serve
    generate
        if (CHANNELS != 16)
        begin : g_bad_channels
            $error("CHANNELS must be 16 to fit the enable register");
        end
        if (FAULT_BITS < 1)
        begin : g_bad_faults
            $error("FAULT_BITS must be at least 1");
        end
    endgenerate

    // ============================================================
    // State record
    typedef struct packed {
        logic [15:0] test_config;
        logic [15:0] bal_enable;
        logic [15:0] bal_config;
        logic [31:0] timeout_count;
        logic trip_armed;
        logic shutdown;
        logic timed_out;
        tcc_wr_state_t wr_state;
        logic [11:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcc_state_t;

    tcc_state_t st_reg;
    tcc_state_t st_next;
    logic any_fault;
    logic [15:0] wmask;
    logic [15:0] cfg_new;
    logic wr_fire;

    // Customer checksum error alone never counts as a fault
    assign any_fault = |fault_bits;

    // ============================================================
    // AXI handshakes: accept each channel once, answer after both
    assign s_axi_awready = ~st_reg.aw_have && (st_reg.wr_state == TCC_WR_IDLE);
    assign s_axi_wready = ~st_reg.w_have && (st_reg.wr_state == TCC_WR_IDLE);
    assign s_axi_bvalid = (st_reg.wr_state == TCC_WR_RESP);
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign wr_fire = st_reg.aw_have && st_reg.w_have && (st_reg.wr_state == TCC_WR_IDLE);
    assign wmask = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};

    // ============================================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        cfg_new = st_reg.test_config;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_next.aw_addr = s_axi_awaddr;
            st_next.aw_have = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
            st_next.w_have = 1'b1;
        end
        // Communication timeout counter
        if (valid_packet && !st_reg.test_config[`TCC_CNT_INHIBIT_BIT])
            st_next.timeout_count = 32'h0000_0000;
        else if (st_reg.timeout_count < comm_power_down_period)
            st_next.timeout_count = st_reg.timeout_count + 32'h0000_0001;
        // Period below count while inhibited: no match, timeout missed
        if (st_reg.timeout_count == comm_power_down_period &&
            comm_power_down_period != 32'h0000_0000)
            st_next.timed_out = 1'b1;
        if (valid_packet && !st_reg.test_config[`TCC_CNT_INHIBIT_BIT])
            st_next.timed_out = 1'b0;
        if (wr_fire)
        begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.wr_state = TCC_WR_RESP;
            st_next.bresp = 2'b00;
            if (st_reg.aw_addr == `TCC_ADDR_TEST_CONFIG)
            begin
                cfg_new = (st_reg.test_config & ~wmask) |
                          (st_reg.w_data[15:0] & wmask);
                // Reserved bits dropped so they read zero
                st_next.test_config = cfg_new & `TCC_TEST_CONFIG_MASK;
            end
            else if (st_reg.aw_addr == `TCC_ADDR_BAL_ENABLE)
            begin
                st_next.bal_enable = (st_reg.bal_enable & ~wmask) |
                                     (st_reg.w_data[15:0] & wmask);
            end
            else if (st_reg.aw_addr == `TCC_ADDR_BAL_CONFIG)
            begin
                st_next.bal_config = ((st_reg.bal_config & ~wmask) |
                                      (st_reg.w_data[15:0] & wmask)) & `TCC_BAL_CONFIG_MASK;
            end
            else if (st_reg.aw_addr == `TCC_ADDR_COMM_TIMEOUT)
            begin
                // Fresh count resynchronises the counter to the period
                st_next.timeout_count = st_reg.w_data;
                st_next.timed_out = 1'b0;
            end
            else
            begin
                st_next.bresp = 2'b10;
            end
        end
        // Setting the trip bit arms; clearing it does not disarm
        if (st_next.test_config[`TCC_VDIG_TRIP_BIT])
            st_next.trip_armed = 1'b1;
        st_next.test_config[`TCC_VDIG_TRIP_BIT] = wr_fire &&
            (st_reg.aw_addr == `TCC_ADDR_TEST_CONFIG) ?
            cfg_new[`TCC_VDIG_TRIP_BIT] : st_reg.test_config[`TCC_VDIG_TRIP_BIT];
        if (st_reg.trip_armed && digital_supply_por_trip)
            st_next.shutdown = 1'b1;
        if (st_reg.shutdown)
            st_next.trip_armed = 1'b0;
        // Faults clear and lock enables; overrides any write this cycle
        if (any_fault && !st_reg.bal_config[`TCC_BAL_CONT_BIT])
            st_next.bal_enable = 16'h0000;
        if (s_axi_bvalid && s_axi_bready)
            st_next.wr_state = TCC_WR_IDLE;
        // Read channel
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = 2'b00;
            st_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == `TCC_ADDR_TEST_CONFIG)
                st_next.rdata = {16'h0000, st_reg.test_config};
            else if (s_axi_araddr == `TCC_ADDR_BAL_ENABLE)
                st_next.rdata = {16'h0000, st_reg.bal_enable};
            else if (s_axi_araddr == `TCC_ADDR_BAL_CONFIG)
                st_next.rdata = {16'h0000, st_reg.bal_config};
            else if (s_axi_araddr == `TCC_ADDR_COMM_TIMEOUT)
                st_next.rdata = st_reg.timeout_count;
            else if (s_axi_araddr == `TCC_ADDR_STATUS)
                st_next.rdata = {29'h0000_0000, st_reg.timed_out,
                                 st_reg.shutdown, st_reg.trip_armed};
            else
                st_next.rresp = 2'b10;
        end
        else if (st_reg.rvalid && s_axi_rready)
        begin
            st_next.rvalid = 1'b0;
        end
    end

    // ============================================================
    // State register; all test features start disabled
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            st_reg <= '0;
            st_reg.wr_state <= TCC_WR_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Outputs straight from the register bits
    assign test_ctl.core_regulator_trial_field =
        st_reg.test_config[`TCC_REG_TRIAL_MSB:`TCC_REG_TRIAL_LSB];
    assign test_ctl.counter_reset_inhibit = st_reg.test_config[`TCC_CNT_INHIBIT_BIT];
    assign test_ctl.digital_supply_trip_armed = st_reg.trip_armed;
    assign test_ctl.squeeze_resistor_enable = st_reg.test_config[`TCC_SQUEEZE_BIT];
    assign test_ctl.charge_pump_monitor_enable = st_reg.test_config[`TCC_CP_MON_BIT];
    assign test_ctl.module_voltage_monitor_enable =
        st_reg.test_config[`TCC_MOD_MON_BIT];
    assign shutdown_request = st_reg.shutdown;
    assign comm_timeout = st_reg.timed_out;

    // Steering of enables to balancing or squeeze outputs
    tcc_drive_select #(
        .CHANNELS(CHANNELS)
    ) u_drive (
        .enable_bits(st_reg.bal_enable),
        .squeeze_on(st_reg.test_config[`TCC_SQUEEZE_BIT]),
        .balance_drive(bal_drive.balance_drive),
        .squeeze_drive(bal_drive.squeeze_drive)
    );
endmodule

// File: tb/tcc_test_config_asserts.sv
/* Concurrent checks on the ports of the test configuration block.
   Assumes one rising-edge clock and an active high asynchronous reset. */
`timescale 1ns/1ns
module tcc_asserts
    import tcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic digital_supply_por_trip,
    input wire tcc_test_ctl_t test_ctl,
    input wire tcc_bal_drive_t bal_drive,
    input wire logic shutdown_request
);
    // ============================================================
    // Read address capture, so read data can be tied to its register
    logic [11:0] rd_addr_reg;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rd_addr_reg <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr_reg <= s_axi_araddr;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ============================================================
    // Properties
    property p_top_zero; s_axi_rvalid && rd_addr_reg == 12'h078 |-> s_axi_rdata[15:12] == 4'h0; endproperty
    a_top_zero: assert property (p_top_zero) else $error("top bits not zero");
    property p_sqz_gate; bal_drive.squeeze_drive != 16'h0000 |-> test_ctl.squeeze_resistor_enable; endproperty
    a_sqz_gate: assert property (p_sqz_gate) else $error("squeeze drive while off");
    property p_sqz_bal; test_ctl.squeeze_resistor_enable |-> bal_drive.balance_drive == 16'h0000; endproperty
    a_sqz_bal: assert property (p_sqz_bal) else $error("balance drive while squeezing");
    property p_trip; test_ctl.digital_supply_trip_armed && digital_supply_por_trip |-> ##[0:2] shutdown_request; endproperty
    a_trip: assert property (p_trip) else $error("armed trip without shutdown");
    property p_cause; $rose(shutdown_request) |-> $past(test_ctl.digital_supply_trip_armed); endproperty
    a_cause: assert property (p_cause) else $error("shutdown while unarmed");
    property p_sticky; shutdown_request |=> shutdown_request; endproperty
    a_sticky: assert property (p_sticky) else $error("shutdown dropped");
    property p_armed; $fell(test_ctl.digital_supply_trip_armed) |-> shutdown_request; endproperty
    a_armed: assert property (p_armed) else $error("arming lost without shutdown");
    // Reset must leave every test feature off
    property p_rst; $fell(reset) |-> test_ctl == '0 && !shutdown_request; endproperty
    a_rst: assert property (p_rst) else $error("test controls not cleared");

    cover property (test_ctl.squeeze_resistor_enable && bal_drive.squeeze_drive != 16'h0000);
    cover property ($rose(shutdown_request));
    cover property (s_axi_rvalid && rd_addr_reg == 12'h078);
endmodule

bind tcc_test_config tcc_asserts i_chk (.sys_clk, .reset, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .digital_supply_por_trip, .test_ctl,
    .bal_drive, .shutdown_request);

// File: tb/test_test_configuration_control.sv
/* Self-checking bench for the test configuration block.
   Assumes the checker file is compiled with it and binds itself. */
`timescale 1ns/1ns
module test_test_configuration_control
    import tcc_pkg::*;
    ;
    // ============================================================
    // Stimulus and observed signals, named as the ports
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, comm_power_down_period = 32'h0000_FFFF;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, valid_packet = 1'h0;
    logic customer_checksum_error = 1'h0, digital_supply_por_trip = 1'h0;
    logic [7:0] fault_bits = 8'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic shutdown_request, comm_timeout;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    tcc_test_ctl_t test_ctl;
    tcc_bal_drive_t bal_drive;
    int errors = 0;
    int num_checks = 0;
    logic [1:0] bresp_seen = 2'h0;

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    tcc_test_config i_dut (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .valid_packet, .fault_bits,
        .customer_checksum_error, .digital_supply_por_trip, .comm_power_down_period,
        .test_ctl, .bal_drive, .shutdown_request, .comm_timeout);

    // ============================================================
    // Verdict and comparison
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        bresp_seen = s_axi_bresp;
    endtask

    // Read and compare; data is only meaningful on an OKAY answer
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        if (er == 2'h0) chk(nm, s_axi_rdata, e);
        chk(nm, {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Packets every ten cycles, well inside a period of thirty
    task automatic run(input int n);
        for (int i = 0; i < n; i++)
            @(posedge sys_clk) valid_packet <= (i % 10 == 0);
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        rd_chk("cfg rst", 12'h078, 32'h0000_0000, 2'h0);
        @(posedge sys_clk) digital_supply_por_trip <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk("unarmed trip", shutdown_request, 32'h0000_0000);
        digital_supply_por_trip <= 1'h0;
        // Only defined bits written; reserved and top bits kept zero
        wr(12'h078, 32'h0000_0FD5);
        chk("bresp ok", {30'h0, bresp_seen}, 32'h0000_0000);
        chk("ctl all", test_ctl, 32'h0000_01FF);
        rd_chk("cfg mask", 12'h078, 32'h0000_0FD5, 2'h0);
        // Regulator trial field back to zero for normal operation
        wr(12'h078, 32'h0000_0000);
        chk("ctl clear", test_ctl, 32'h0000_0008);
        rd_chk("trip reads 0", 12'h078, 32'h0000_0000, 2'h0);
        wr(12'h050, 32'h0000_8001);
        chk("bal route", bal_drive, 32'h8001_0000);
        // Balance-continue on while the squeeze resistors are used
        wr(12'h04C, 32'h0000_0008);
        wr(12'h078, 32'h0000_0010);
        chk("sqz route", bal_drive, 32'h0000_8001);
        wr(12'h078, 32'h0000_0000);
        wr(12'h04C, 32'h0000_0000);
        // Fault clears enables and blocks writes until continue is set
        @(posedge sys_clk) fault_bits <= 8'h04;
        repeat (2) @(posedge sys_clk);
        chk("fault clr", bal_drive, 32'h0000_0000);
        wr(12'h050, 32'h0000_00FF);
        rd_chk("fault ign", 12'h050, 32'h0000_0000, 2'h0);
        wr(12'h04C, 32'h0000_0008);
        wr(12'h050, 32'h0000_0003);
        rd_chk("continue", 12'h050, 32'h0000_0003, 2'h0);
        wr(12'h04C, 32'h0000_0000);
        @(posedge sys_clk) fault_bits <= 8'h00;
        customer_checksum_error <= 1'h1;
        wr(12'h050, 32'h0000_0005);
        rd_chk("cksum ign", 12'h050, 32'h0000_0005, 2'h0);
        rd_chk("unmapped", 12'h0F0, 32'h0000_0000, 2'h2);
        wr(12'h0F0, 32'h0000_0001);
        chk("bresp err", {30'h0, bresp_seen}, 32'h0000_0002);
        // Timeout: packets hold it off; with inhibit on they do not, and a late low period misses it
        @(posedge sys_clk) comm_power_down_period <= 32'h0000_001E;
        wr(12'h100, 32'h0000_0000);
        run(100);
        chk("no tmo", comm_timeout, 32'h0000_0000);
        // Period settled before the inhibit bit goes on
        @(posedge sys_clk) comm_power_down_period <= 32'h0000_FFFF;
        wr(12'h078, 32'h0000_0080);
        run(60);
        @(posedge sys_clk) comm_power_down_period <= 32'h0000_001E;
        run(100);
        chk("missed tmo", comm_timeout, 32'h0000_0000);
        wr(12'h100, 32'h0000_0000);
        run(60);
        chk("tmo back", comm_timeout, 32'h0000_0001);
        @(posedge sys_clk) digital_supply_por_trip <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk("shutdown", shutdown_request, 32'h0000_0001);
        chk("disarmed", test_ctl.digital_supply_trip_armed, 32'h0000_0000);
        rd_chk("status", 12'h104, 32'h0000_0006, 2'h0);
        // Mid-run reset clears the sticky shutdown and every test feature
        @(posedge sys_clk) reset <= 1'h1;
        @(posedge sys_clk) reset <= 1'h0;
        chk("rst shutdown", shutdown_request, 32'h0000_0000);
        chk("rst ctl", test_ctl, 32'h0000_0000);
        rd_chk("rst status", 12'h104, 32'h0000_0000, 2'h0);
        summarize();
    end

    // Watchdog well past the several hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        summarize();
    end
endmodule
